/* alu_bit_ops_exec.sv */
// Notes on behaviour
// RL1: Add-immediate adds the 8-bit immediate to the accumulator, keeps the sum there and updates carry, digit carry and zero.
// RL2: Add-register adds the accumulator and the indexed file register and updates carry, digit carry and zero.
// RL3: Register-form arithmetic and logic results go to the accumulator when target_select is 0 and to the file register when it is 1.
// RL4: And-immediate ANDs the accumulator with the immediate, keeps the result there and updates only zero.
// RL5: And-register ANDs the accumulator with the indexed file register, sends it to the chosen target and updates only zero.
// RL6: Clear-bit forces the chosen bit of the file register to zero, keeps the rest and touches no flag.
// RL7: Set-bit forces the chosen bit of the file register to one, keeps the rest and touches no flag.
// RL8: Skip-if-high with the tested bit at one discards the next instruction and runs a no-op instead.
// RL9: Skip-if-low with the tested bit at zero discards the next instruction, and neither skip changes a flag.
// RL10: A skip whose test fails lets the next instruction run with no inserted no-op.
// RL11: A true conditional test costs two instruction cycles, the second one a no-op; the rest take one.
// RL12: A read-modify-write of the port register reads the synchronised pin levels, not the output latch.
// RL13: Zero flags an all-zero result, carry is the carry out of bit 7 and digit carry the carry out of bit 3.
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/10ps
`include "alu_bit_ops_map.svh"

module alu_bit_ops_exec (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic instr_valid,
    input wire alu_bit_ops_pkg::op_t instr_op,
    input wire logic [7:0] immediate_value,
    input wire logic [6:0] operand_register_index,
    input wire logic target_select,
    input wire logic [2:0] position_index,
    input wire logic [7:0] port_pins,
    output logic [7:0] port_latch,
    output logic [7:0] accumulator,
    output logic carry_out,
    output logic nibble_overflow_out,
    output logic zero_out,
    output logic nop_cycle,
    output logic instr_done
);

    alu_bit_ops_pkg::state_t state_reg;
    alu_bit_ops_pkg::state_t state_next;

    logic fire;
    logic [7:0] operand;
    logic [8:0] sum9;
    logic [4:0] sum5;
    logic [7:0] result;
    logic tested_bit;
    logic [7:0] bit_mask;
    logic apb_setup;
    logic apb_write;

    // ****************************************
    // Operand fetch and arithmetic
    // ****************************************
    assign fire = instr_valid && state_reg.exec_en && !state_reg.skip_pending;
    // Port register reads the pins
    assign operand = (operand_register_index == `PORT_IDX) ? state_reg.pin_sync : // RL12
        state_reg.files[operand_register_index];
    assign sum9 = {1'b0, state_reg.acc} + {1'b0, operand}; // RL2 RL13
    assign sum5 = {1'b0, state_reg.acc[3:0]} + {1'b0, operand[3:0]}; // RL13
    assign tested_bit = operand[position_index];
    assign bit_mask = 8'h01 << position_index;
    assign apb_setup = psel && !penable;
    assign apb_write = psel && penable && state_reg.pready && pwrite;

    always_comb begin
        logic [8:0] imm9;
        logic [4:0] imm5;
        imm9 = {1'b0, state_reg.acc} + {1'b0, immediate_value};
        imm5 = {1'b0, state_reg.acc[3:0]} + {1'b0, immediate_value[3:0]};
        state_next = state_reg;
        result = 8'h00;
        state_next.pin_meta = port_pins;
        state_next.pin_sync = state_reg.pin_meta;
        state_next.nop_cycle = 1'b0;
        state_next.done = 1'b0;

        // ****************************************
        // APB slave
        // ****************************************
        if (apb_setup) begin
            state_next.pready = 1'b1;
            state_next.pslverr = 1'b0;
            state_next.prdata = `RDATA_ZERO;
            unique case (paddr)
                `ACC_OFS: begin
                    state_next.prdata[7:0] = state_reg.acc;
                end
                `FLAGS_OFS: begin
                    state_next.prdata[`FLG_C] = state_reg.carry;
                    state_next.prdata[`FLG_NIB] = state_reg.nibble;
                    state_next.prdata[`FLG_Z] = state_reg.zero;
                end
                `CTRL_OFS: begin
                    state_next.prdata[`CTRL_EN] = state_reg.exec_en;
                end
                `FIDX_OFS: begin
                    state_next.prdata[6:0] = state_reg.file_idx;
                end
                `FDATA_OFS: begin
                    state_next.prdata[7:0] = (state_reg.file_idx == `PORT_IDX) ?
                        state_reg.pin_sync : state_reg.files[state_reg.file_idx];
                end
                `STATE_OFS: begin
                    state_next.prdata[`STATE_SKIP] = state_reg.skip_pending;
                end
                default: begin
                    state_next.pslverr = 1'b1;
                end
            endcase
        end else begin
            state_next.pready = 1'b0;
            state_next.pslverr = 1'b0;
        end

        if (apb_write) begin
            unique case (paddr)
                `ACC_OFS: state_next.acc = pwdata[7:0];
                `FLAGS_OFS: begin
                    state_next.carry = pwdata[`FLG_C];
                    state_next.nibble = pwdata[`FLG_NIB];
                    state_next.zero = pwdata[`FLG_Z];
                end
                `CTRL_OFS: state_next.exec_en = pwdata[`CTRL_EN];
                `FIDX_OFS: state_next.file_idx = pwdata[6:0];
                `FDATA_OFS: state_next.files[state_reg.file_idx] = pwdata[7:0];
                default: begin
                end
            endcase
        end

        // ****************************************
        // Execution, overrides a same-cycle bus write
        // ****************************************
        if (instr_valid && state_reg.skip_pending) begin
            // Discarded instruction runs as a no-op
            state_next.skip_pending = 1'b0; // RL11
            state_next.nop_cycle = 1'b1; // RL8 RL9
            state_next.done = 1'b1;
        end else if (fire) begin
            state_next.done = 1'b1;
            unique case (instr_op)
                alu_bit_ops_pkg::add_immediate_op: begin
                    state_next.acc = imm9[7:0]; // RL1
                    state_next.carry = imm9[8]; // RL13
                    state_next.nibble = imm5[4];
                    state_next.zero = (imm9[7:0] == 8'h00);
                end
                alu_bit_ops_pkg::add_register_op: begin
                    result = sum9[7:0];
                    state_next.carry = sum9[8]; // RL2
                    state_next.nibble = sum5[4];
                    state_next.zero = (sum9[7:0] == 8'h00);
                end
                alu_bit_ops_pkg::and_immediate_op: begin
                    state_next.acc = state_reg.acc & immediate_value; // RL4
                    state_next.zero = ((state_reg.acc & immediate_value) == 8'h00);
                end
                alu_bit_ops_pkg::and_register_op: begin
                    result = state_reg.acc & operand; // RL5
                    state_next.zero = (result == 8'h00);
                end
                alu_bit_ops_pkg::clear_bit_op: begin
                    state_next.files[operand_register_index] = operand & ~bit_mask; // RL6
                end
                alu_bit_ops_pkg::set_bit_op: begin
                    state_next.files[operand_register_index] = operand | bit_mask; // RL7
                end
                alu_bit_ops_pkg::skip_if_bit_high_op: begin
                    state_next.skip_pending = tested_bit; // RL8 RL10
                end
                alu_bit_ops_pkg::skip_if_bit_low_op: begin
                    state_next.skip_pending = !tested_bit; // RL9 RL10
                end
                default: begin
                end
            endcase
            if (instr_op == alu_bit_ops_pkg::add_register_op ||
                instr_op == alu_bit_ops_pkg::and_register_op) begin
                if (target_select) begin
                    state_next.files[operand_register_index] = result; // RL3
                end else begin
                    state_next.acc = result; // RL3
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= '0;
            state_reg.acc <= `ACC_RST;
            state_reg.exec_en <= `CTRL_EN_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign prdata = state_reg.prdata;
    assign pready = state_reg.pready;
    assign pslverr = state_reg.pslverr;
    assign port_latch = state_reg.files[`PORT_IDX];
    assign accumulator = state_reg.acc;
    assign carry_out = state_reg.carry;
    assign nibble_overflow_out = state_reg.nibble;
    assign zero_out = state_reg.zero;
    assign nop_cycle = state_reg.nop_cycle;
    assign instr_done = state_reg.done;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    add_imm_sum_a: assert property ( // RL1
        fire && instr_op == alu_bit_ops_pkg::add_immediate_op
        |=> accumulator == $past(state_reg.acc + immediate_value) && instr_done)
        else $error("add immediate sum wrong");

    add_reg_flags_a: assert property ( // RL13
        fire && instr_op == alu_bit_ops_pkg::add_register_op
        |=> carry_out == $past(sum9[8]) && nibble_overflow_out == $past(sum5[4])
            && zero_out == ($past(sum9[7:0]) == 8'h00))
        else $error("add flags wrong");

    reg_target_a: assert property ( // RL3
        fire && instr_op == alu_bit_ops_pkg::add_register_op && target_select
        && !apb_write |=> accumulator == $past(state_reg.acc))
        else $error("register target changed accumulator");

    and_flags_a: assert property ( // RL5
        fire && (instr_op == alu_bit_ops_pkg::and_register_op ||
        instr_op == alu_bit_ops_pkg::and_immediate_op) && !apb_write
        |=> $stable(carry_out) && $stable(nibble_overflow_out))
        else $error("and changed carry flags");

    clear_bit_a: assert property ( // RL6
        fire && instr_op == alu_bit_ops_pkg::clear_bit_op
        |=> state_reg.files[$past(operand_register_index)][$past(position_index)] == 1'b0)
        else $error("bit not cleared");

    set_bit_a: assert property ( // RL7
        fire && instr_op == alu_bit_ops_pkg::set_bit_op
        |=> state_reg.files[$past(operand_register_index)][$past(position_index)] == 1'b1)
        else $error("bit not set");

    skip_high_a: assert property ( // RL8
        fire && instr_op == alu_bit_ops_pkg::skip_if_bit_high_op && tested_bit
        |=> state_reg.skip_pending && instr_done && !nop_cycle)
        else $error("skip high not armed");

    skip_low_a: assert property ( // RL9
        fire && instr_op == alu_bit_ops_pkg::skip_if_bit_low_op && !tested_bit
        && !apb_write |=> state_reg.skip_pending && $stable(zero_out))
        else $error("skip low not armed");

    no_skip_a: assert property ( // RL10
        fire && instr_op == alu_bit_ops_pkg::skip_if_bit_high_op && !tested_bit
        |=> !state_reg.skip_pending)
        else $error("skip armed on false test");

    one_nop_a: assert property ( // RL11
        instr_valid && state_reg.skip_pending && !apb_write
        |=> nop_cycle && instr_done && !state_reg.skip_pending && $stable(accumulator)
            && $stable(zero_out) && $stable(carry_out))
        else $error("discarded instruction not run as no-op");

    pin_read_a: assert property ( // RL12
        fire && instr_op == alu_bit_ops_pkg::and_register_op && !target_select
        && operand_register_index == `PORT_IDX && !apb_write
        |=> accumulator == $past(state_reg.acc & state_reg.pin_sync))
        else $error("port read used latch");

endmodule : alu_bit_ops_exec

/* alu_bit_ops_exec_tb_top.sv */
`timescale 1ns/10ps
`include "alu_bit_ops_map.svh"

module alu_bit_ops_exec_tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, go, tgt_s, target_select;
    logic instr_valid, carry_out, nibble_overflow_out, zero_out, nop_cycle, instr_done;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd_v, seed;
    logic [7:0] imm_s, immediate_value, port_pins, port_latch, accumulator;
    logic [6:0] idx_s, operand_register_index, idx_v;
    logic [2:0] pos_s, position_index;
    alu_bit_ops_pkg::op_t op_s, instr_op;
    logic [7:0] files_m [128];
    logic [7:0] acc_m;
    logic c_m, nib_m, z_m, skip_m, en_m, err_v;
    int fail_count, total_checks;

    alu_bit_ops_exec u_alu_bit_ops_exec (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .instr_valid(instr_valid), .instr_op(instr_op),
        .immediate_value(immediate_value), .operand_register_index(operand_register_index),
        .target_select(target_select), .position_index(position_index),
        .port_pins(port_pins), .port_latch(port_latch), .accumulator(accumulator),
        .carry_out(carry_out), .nibble_overflow_out(nibble_overflow_out),
        .zero_out(zero_out), .nop_cycle(nop_cycle), .instr_done(instr_done));

    instr_feeder u_instr_feeder (.pclk(pclk), .presetn(presetn), .go(go), .op_s(op_s),
        .imm_s(imm_s), .idx_s(idx_s), .tgt_s(tgt_s), .pos_s(pos_s),
        .instr_valid(instr_valid), .instr_op(instr_op), .immediate_value(immediate_value),
        .operand_register_index(operand_register_index), .target_select(target_select),
        .position_index(position_index));

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wrap_up;
        if (fail_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // Outputs read before the edge's own updates land
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd_v = prdata;
        err_v = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic run_op(input alu_bit_ops_pkg::op_t op, input logic [7:0] imm,
            input logic [6:0] idx, input logic tgt, input logic [2:0] pos);
        logic [8:0] s;
        logic [7:0] b, r;
        logic dn, np, alu, rop;
        int n;
        rop = op == alu_bit_ops_pkg::add_register_op || op == alu_bit_ops_pkg::and_register_op;
        alu = rop || op == alu_bit_ops_pkg::add_immediate_op
            || op == alu_bit_ops_pkg::and_immediate_op;
        b = rop ? files_m[idx] : imm;
        s = {1'b0, acc_m} + {1'b0, b};
        np = skip_m;
        dn = skip_m | en_m;
        if (skip_m) skip_m = 1'b0;
        else if (en_m) begin
            case (op)
                alu_bit_ops_pkg::add_immediate_op, alu_bit_ops_pkg::add_register_op: begin
                    r = s[7:0];
                    c_m = s[8];
                    nib_m = ({1'b0, acc_m[3:0]} + {1'b0, b[3:0]}) > 5'd15;
                    z_m = r == 8'h00;
                end
                alu_bit_ops_pkg::and_immediate_op, alu_bit_ops_pkg::and_register_op: begin
                    r = acc_m & b;
                    z_m = r == 8'h00;
                end
                alu_bit_ops_pkg::clear_bit_op: files_m[idx][pos] = 1'b0;
                alu_bit_ops_pkg::set_bit_op: files_m[idx][pos] = 1'b1;
                alu_bit_ops_pkg::skip_if_bit_high_op: skip_m = files_m[idx][pos];
                alu_bit_ops_pkg::skip_if_bit_low_op: skip_m = !files_m[idx][pos];
                default: ;
            endcase
            if (alu && rop && tgt) files_m[idx] = r;
            else if (alu) acc_m = r;
        end
        @(posedge pclk);
        go <= 1'b1;
        op_s <= op;
        imm_s <= imm;
        idx_s <= idx;
        tgt_s <= tgt;
        pos_s <= pos;
        @(posedge pclk);
        go <= 1'b0;
        n = 0;
        do begin @(negedge pclk); n++; end while (instr_done !== 1'b1 && n < 4);
        check(instr_done, dn);
        check(nop_cycle, np & dn);
        check(accumulator, acc_m);
        check({carry_out, nibble_overflow_out, zero_out}, {c_m, nib_m, z_m});
    endtask : run_op

    // ****************************************
    // Clock, watchdog and main sequence
    // ****************************************
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    initial begin
        #200000;
        fail_count++;
        wrap_up();
    end

    initial begin
        {presetn, psel, penable, pwrite, go, tgt_s} = '0;
        {paddr, pwdata, imm_s, idx_s, pos_s} = '0;
        op_s = alu_bit_ops_pkg::no_op;
        {acc_m, c_m, nib_m, z_m, skip_m} = '0;
        en_m = 1'b1;
        seed = 32'h6053_f0dc;
        port_pins = seed[7:0];
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `CTRL_OFS, 32'h0000_0000);
        check(rd_v, 32'h0000_0001);
        check({accumulator, carry_out, nibble_overflow_out, zero_out}, 32'h0000_0000);
        apb(1'b0, 12'h0ff, 32'h0000_0000);
        check({err_v, rd_v}, {1'b1, 32'h0000_0000});
        apb(1'b1, `ACC_OFS, 32'h0000_0001);
        acc_m = 8'h01;
        run_op(alu_bit_ops_pkg::add_immediate_op, 8'hff, 7'h00, 1'b0, 3'h0);
        apb(1'b0, `FLAGS_OFS, 32'h0000_0000);
        check(rd_v, {29'h0, z_m, nib_m, c_m});
        apb(1'b1, `FLAGS_OFS, 32'h0000_0005);
        {z_m, nib_m, c_m} = 3'b101;
        apb(1'b0, `ACC_OFS, 32'h0000_0000);
        check(rd_v, {24'h0, acc_m});
        for (int i = 0; i < 60; i++) begin
            seed = lfsr(seed);
            idx_v = (seed[10:4] == `PORT_IDX) ? 7'h07 : seed[10:4];
            apb(1'b1, `FIDX_OFS, {25'h0, idx_v});
            apb(1'b1, `FDATA_OFS, {24'h0, seed[31:24]});
            files_m[idx_v] = seed[31:24];
            if (i == 40) begin
                apb(1'b1, `CTRL_OFS, 32'h0000_0000);
                en_m = 1'b0;
            end
            // Codes 1 to 8: every executed operation
            run_op(alu_bit_ops_pkg::op_t'({1'b0, seed[2:0]} + 4'd1),
                seed[19:12], idx_v, seed[20], seed[23:21]);
            apb(1'b0, `FDATA_OFS, 32'h0000_0000);
            check(rd_v, {24'h0, files_m[idx_v]});
            apb(1'b1, `STATE_OFS, 32'h0000_0000);
            apb(1'b0, `STATE_OFS, 32'h0000_0000);
            check(rd_v, {31'h0, skip_m});
            if (i == 44) begin
                apb(1'b1, `CTRL_OFS, 32'h0000_0001);
                en_m = 1'b1;
            end
        end
        if (skip_m) run_op(alu_bit_ops_pkg::no_op, 8'h00, 7'h00, 1'b0, 3'h0);
        apb(1'b1, `FIDX_OFS, {25'h0, `PORT_IDX});
        apb(1'b1, `FDATA_OFS, 32'h0000_0000);
        files_m[`PORT_IDX] = port_pins;
        run_op(alu_bit_ops_pkg::set_bit_op, 8'h00, `PORT_IDX, 1'b0, ~port_pins[2:0]);
        check(port_latch, files_m[`PORT_IDX]);
        files_m[`PORT_IDX] = port_pins;
        run_op(alu_bit_ops_pkg::and_register_op, 8'h00, `PORT_IDX, 1'b0, 3'h0);
        wrap_up();
    end
endmodule : alu_bit_ops_exec_tb_top

/* alu_bit_ops_map.svh */
`ifndef ALU_BIT_OPS_MAP_SVH
`define ALU_BIT_OPS_MAP_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define ACC_OFS 12'h000
`define FLAGS_OFS 12'h004
`define CTRL_OFS 12'h008
`define FIDX_OFS 12'h00C
`define FDATA_OFS 12'h010
`define STATE_OFS 12'h014

// ****************************************
// Field positions
// ****************************************
`define FLG_C 0
`define FLG_NIB 1
`define FLG_Z 2
`define CTRL_EN 0
`define STATE_SKIP 0

// ****************************************
// Constants
// ****************************************
`define PORT_IDX 7'h06
`define ACC_RST 8'h00
`define CTRL_EN_RST 1'b1
`define RDATA_ZERO 32'h0000_0000

`endif

/* alu_bit_ops_pkg.sv */
package alu_bit_ops_pkg;

    typedef enum logic [3:0] {
        no_op,
        add_immediate_op,
        add_register_op,
        and_immediate_op,
        and_register_op,
        clear_bit_op,
        set_bit_op,
        skip_if_bit_high_op,
        skip_if_bit_low_op
    } op_t;

    typedef struct packed {
        logic [7:0] acc;
        logic carry;
        logic nibble;
        logic zero;
        logic [127:0][7:0] files;
        logic [7:0] pin_meta;
        logic [7:0] pin_sync;
        logic skip_pending;
        logic exec_en;
        logic [6:0] file_idx;
        logic nop_cycle;
        logic done;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } state_t;

endpackage : alu_bit_ops_pkg

/* instr_feeder.sv */
`timescale 1ns/10ps

// ****************************************
// Instruction decoder model
// ****************************************
module instr_feeder (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic go,
    input wire alu_bit_ops_pkg::op_t op_s,
    input wire logic [7:0] imm_s,
    input wire logic [6:0] idx_s,
    input wire logic tgt_s,
    input wire logic [2:0] pos_s,
    output logic instr_valid,
    output alu_bit_ops_pkg::op_t instr_op,
    output logic [7:0] immediate_value,
    output logic [6:0] operand_register_index,
    output logic target_select,
    output logic [2:0] position_index
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instr_valid <= 1'b0;
            instr_op <= alu_bit_ops_pkg::no_op;
            immediate_value <= 8'h00;
            operand_register_index <= 7'h00;
            target_select <= 1'b0;
            position_index <= 3'h0;
        end else if (go) begin
            instr_valid <= 1'b1;
            instr_op <= op_s;
            immediate_value <= imm_s;
            operand_register_index <= idx_s;
            target_select <= tgt_s;
            position_index <= pos_s;
        end else begin
            // Idle operand lines toggle, never hold stale values
            instr_valid <= 1'b0;
            immediate_value <= ~immediate_value;
            operand_register_index <= ~operand_register_index;
            target_select <= ~target_select;
            position_index <= ~position_index;
        end
    end
endmodule : instr_feeder
